// ---- logic/spb_pkg.sv ----
// spb_pkg: constants and types shared by the burst memory port
// assumes one 40 MHz clock domain; the wide four-lane variant is built
package spb_pkg;
    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int SLOT_W = LANE_W + 1;
    localparam int WORD_W = LANES * SLOT_W;
    localparam int LOW_W = 2;
    localparam int HI_W = ADDR_W - LOW_W;
    localparam int DEPTH = 2 ** ADDR_W;
    // slots of the filtered asynchronous inputs
    localparam int AS_OE = 0;
    localparam int AS_SLEEP = 1;
    localparam int AS_ORDER = 2;
    localparam int AS_N = 3;
    // outputs off, awake, interleaved order
    localparam logic [AS_N-1:0] AS_RST = 3'h5;
    localparam logic ORDER_LINEAR = 1'h0;
    // slots of the filtered scan pins
    localparam int SC_TCK = 0;
    localparam int SC_TDI = 1;
    localparam int SC_TMS = 2;
    localparam int SC_N = 3;
    localparam logic [SC_N-1:0] SC_RST = 3'h4;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3, TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5,
        TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
        TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } spb_tap_e;
endpackage : spb_pkg

// ---- logic/spb_burst.sv ----
// spb_burst: two-bit wrapping burst counter with linear or xor order
// assumes load and step come from the port's sampled controls
`timescale 1ns/100ps
module spb_burst
    import spb_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [LOW_W-1:0] start_i,
    input wire logic step_i,
    input wire logic order_i,
    output logic [LOW_W-1:0] cur_o,
    output logic [LOW_W-1:0] nxt_o
);
    logic [LOW_W-1:0] start_r;
    logic [LOW_W-1:0] start_nxt;
    logic [LOW_W-1:0] cnt_r;
    logic [LOW_W-1:0] cnt_nxt;
    logic [LOW_W-1:0] cnt_inc;

    function automatic logic [LOW_W-1:0] seq_f(input logic o,
        input logic [LOW_W-1:0] s, input logic [LOW_W-1:0] c);
        seq_f = (o == ORDER_LINEAR) ? LOW_W'(s + c) : (s ^ c);
    endfunction : seq_f

    always_comb
    begin
        cnt_inc = LOW_W'(cnt_r + 2'h1);
        start_nxt = start_r;
        cnt_nxt = cnt_r;
        if (load_i)
        begin
            start_nxt = start_i;
            cnt_nxt = '0;
        end
        else if (step_i)
        begin
            cnt_nxt = cnt_inc;
        end
        cur_o = seq_f(order_i, start_r, cnt_r);
        nxt_o = seq_f(order_i, start_r, cnt_inc);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            start_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            start_r <= start_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    property p_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        load_i |=> cnt_r == 2'h0 && start_r == $past(start_i);
    endproperty
    a_load: assert property (p_load)
        else $error("burst load did not take the start bits");
    property p_wrap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cnt_r == 2'h3 && step_i && !load_i) |=> cnt_r == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst counter did not wrap");
    property p_step;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (step_i && !load_i && $stable(order_i)) |=> cur_o == $past(nxt_o);
    endproperty
    a_step: assert property (p_step)
        else $error("burst address did not advance");
    sequence s_load_one(o);
        load_i && start_i == 2'h1 && order_i == o ##1 step_i && !load_i;
    endsequence
    property p_lin;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_load_one(ORDER_LINEAR) |=> cur_o == 2'h2;
    endproperty
    a_lin: assert property (p_lin)
        else $error("linear burst order wrong");
    property p_ilv;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_load_one(!ORDER_LINEAR) |=> cur_o == 2'h0;
    endproperty
    a_ilv: assert property (p_ilv)
        else $error("interleaved burst order wrong");
endmodule : spb_burst

// ---- logic/spb_scan.sv ----
// spb_scan: boundary-scan access port with a bypass data path only
// assumes scan pins are asynchronous; test clock is sampled, not a clock
`timescale 1ns/100ps
module spb_scan
    import spb_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic scan_clk_i,
    input wire logic scan_in_i,
    input wire logic scan_mode_i,
    output logic scan_out_o,
    output logic scan_out_oe_o
);
    logic [SC_N-1:0] s1_r, s2_r, s3_r, f_r, f_nxt;
    logic rise, fall, shdr, shir, byp_r, byp_nxt, tdo_r, tdo_nxt;
    logic oe_r, oe_nxt;
    logic [1:0] ir_r, ir_nxt;
    spb_tap_e st_r, st_nxt;

    // a scan pin counts only once the last two stages agree
    for (genvar i = 0; i < SC_N; i++)
    begin : g_flt
        assign f_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : f_r[i];
    end
    assign rise = f_nxt[SC_TCK] && !f_r[SC_TCK];
    assign fall = !f_nxt[SC_TCK] && f_r[SC_TCK];
    assign shdr = (st_r == TAP_SH_DR);
    assign shir = (st_r == TAP_SH_IR);

    always_comb
    begin
        logic m;
        m = f_r[SC_TMS];
        st_nxt = st_r;
        byp_nxt = byp_r;
        ir_nxt = ir_r;
        tdo_nxt = tdo_r;
        oe_nxt = oe_r;
        if (rise)
        begin
            unique case (st_r)
                TAP_RESET: st_nxt = m ? TAP_RESET : TAP_IDLE;
                TAP_IDLE: st_nxt = m ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: st_nxt = m ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: st_nxt = m ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR: st_nxt = m ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: st_nxt = m ? TAP_UPD_DR : TAP_PAU_DR;
                TAP_PAU_DR: st_nxt = m ? TAP_EX2_DR : TAP_PAU_DR;
                TAP_EX2_DR: st_nxt = m ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: st_nxt = m ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: st_nxt = m ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: st_nxt = m ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR: st_nxt = m ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: st_nxt = m ? TAP_UPD_IR : TAP_PAU_IR;
                TAP_PAU_IR: st_nxt = m ? TAP_EX2_IR : TAP_PAU_IR;
                TAP_EX2_IR: st_nxt = m ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: st_nxt = m ? TAP_SEL_DR : TAP_IDLE;
            endcase
            if (st_r == TAP_CAP_DR)
                byp_nxt = 1'h0;
            if (shdr)
                byp_nxt = f_r[SC_TDI];
            if (st_r == TAP_CAP_IR)
                ir_nxt = IR_CAPTURE;
            if (shir)
                ir_nxt = {f_r[SC_TDI], ir_r[1]};
        end
        if (fall)
        begin
            tdo_nxt = shdr ? byp_r : ir_r[0];
            oe_nxt = shdr || shir;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_r <= SC_RST;
            s2_r <= SC_RST;
            s3_r <= SC_RST;
            f_r <= SC_RST;
            st_r <= TAP_RESET;
            byp_r <= 1'h0;
            ir_r <= IR_CAPTURE;
            tdo_r <= 1'h0;
            oe_r <= 1'h0;
        end
        else
        begin
            s1_r <= {scan_mode_i, scan_in_i, scan_clk_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
            f_r <= f_nxt;
            st_r <= st_nxt;
            byp_r <= byp_nxt;
            ir_r <= ir_nxt;
            tdo_r <= tdo_nxt;
            oe_r <= oe_nxt;
        end
    end
    assign scan_out_o = tdo_r;
    assign scan_out_oe_o = oe_r;

    property p_tdo_fall;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !fall |=> $stable(scan_out_o) && $stable(scan_out_oe_o);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall)
        else $error("scan output moved off a falling test clock");
    property p_tdi_rise;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rise && shdr) |=> byp_r == $past(f_r[SC_TDI]);
    endproperty
    a_tdi_rise: assert property (p_tdi_rise)
        else $error("scan input not shifted on rising test clock");
    property p_tms;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rise && st_r == TAP_IDLE) |=>
            st_r == ($past(f_r[SC_TMS]) ? TAP_SEL_DR : TAP_IDLE);
    endproperty
    a_tms: assert property (p_tms)
        else $error("mode select did not steer the access port");
endmodule : spb_scan

// ---- logic/spb_port.sv ----
// spb_port: synchronous pipelined burst memory with common byte lanes
// assumes the far side drives sync pins on ref_clk_i; async pins filtered
`timescale 1ns/100ps
module spb_port
    import spb_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic chip_sel_primary_n_i,
    input wire logic chip_sel_second_i,
    input wire logic chip_sel_third_n_i,
    input wire logic cpu_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic burst_step_n_i,
    input wire logic byte_write_enable_n_i,
    input wire logic [LANES-1:0] lane_write_select_n_i,
    input wire logic all_lanes_write_n_i,
    input wire logic out_enable_n_i,
    input wire logic burst_order_i,
    input wire logic sleep_req_i,
    input wire logic [DATA_W-1:0] data_lane_i,
    input wire logic [LANES-1:0] parity_lane_i,
    output logic [DATA_W-1:0] data_lane_o,
    output logic [LANES-1:0] parity_lane_o,
    output logic data_lane_oe_o,
    input wire logic scan_clk_i,
    input wire logic scan_in_i,
    input wire logic scan_mode_i,
    output logic scan_out_o,
    output logic scan_out_oe_o
);
    logic [AS_N-1:0] as_raw;
    logic [AS_N-1:0] as1_r;
    logic [AS_N-1:0] as2_r;
    logic [AS_N-1:0] as3_r;
    logic [AS_N-1:0] as_f_r;
    logic [AS_N-1:0] as_f_nxt;
    logic oe_n_s;
    logic sleep_s;
    logic order_s;

    logic sel_now, cpu_ok, ctrl_ok, strobe, start, desel, cont;
    logic step, wr_now, rd_now;
    logic [LANES-1:0] be;
    logic [ADDR_W-1:0] eff;
    logic [LOW_W-1:0] cur_low, nxt_low;

    logic sel_r, sel_nxt;
    logic emerge_r, emerge_nxt;
    logic [HI_W-1:0] hi_r, hi_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [LANES-1:0] wr_be_r, wr_be_nxt;
    logic [WORD_W-1:0] din_r, din_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic [WORD_W-1:0] dout_r, dout_nxt;
    logic valid_r, valid_nxt;

    // contents survive sleep and reset alike, so the array has no reset
    logic [WORD_W-1:0] mem [DEPTH];

    // asynchronous pins: a change counts once stages two and three agree
    assign as_raw[AS_OE] = out_enable_n_i;
    assign as_raw[AS_SLEEP] = sleep_req_i;
    assign as_raw[AS_ORDER] = burst_order_i;
    for (genvar i = 0; i < AS_N; i++)
    begin : g_flt
        assign as_f_nxt[i] = (as2_r[i] == as3_r[i]) ? as3_r[i] : as_f_r[i];
    end
    assign oe_n_s = as_f_r[AS_OE];
    assign sleep_s = as_f_r[AS_SLEEP];
    // strap is read live; it is expected to move only while the bus is idle
    assign order_s = as_f_r[AS_ORDER];

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            as1_r <= AS_RST;
            as2_r <= AS_RST;
            as3_r <= AS_RST;
            as_f_r <= AS_RST;
        end
        else
        begin
            as1_r <= as_raw;
            as2_r <= as1_r;
            as3_r <= as2_r;
            as_f_r <= as_f_nxt;
        end
    end

    spb_burst u_burst (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(start),
        .start_i(addr_i[LOW_W-1:0]),
        .step_i(step),
        .order_i(order_s),
        .cur_o(cur_low),
        .nxt_o(nxt_low)
    );

    spb_scan u_scan (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .scan_clk_i(scan_clk_i),
        .scan_in_i(scan_in_i),
        .scan_mode_i(scan_mode_i),
        .scan_out_o(scan_out_o),
        .scan_out_oe_o(scan_out_oe_o)
    );

    // sampled controls of the current edge
    always_comb
    begin
        sel_now = !chip_sel_primary_n_i && chip_sel_second_i
            && !chip_sel_third_n_i;
        cpu_ok = !cpu_addr_strobe_n_i && !chip_sel_primary_n_i
            && !sleep_s;
        ctrl_ok = !ctrl_addr_strobe_n_i && !cpu_ok && !sleep_s;
        strobe = cpu_ok || ctrl_ok;
        start = strobe && sel_now;
        desel = strobe && !sel_now;
        // a deselect needs an accepted strobe; selects alone change nothing
        cont = !strobe && sel_r && !sleep_s;
        step = cont && !burst_step_n_i;
        if (!all_lanes_write_n_i)
            be = '1;
        else if (!byte_write_enable_n_i)
            be = ~lane_write_select_n_i;
        else
            be = '0;
        // the cpu strobe cycle ignores the write pins
        wr_now = ((start && ctrl_ok) || cont) && (|be);
        rd_now = (start || cont) && !wr_now;
        if (start)
            eff = addr_i;
        else
            eff = {hi_r, step ? nxt_low : cur_low};
    end

    // lane packing: each slot is parity over eight data bits
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        assign din_nxt[i*SLOT_W +: SLOT_W] =
            {parity_lane_i[i], data_lane_i[i*LANE_W +: LANE_W]};
        assign data_lane_o[i*LANE_W +: LANE_W] =
            dout_r[i*SLOT_W +: LANE_W];
        assign parity_lane_o[i] = dout_r[i*SLOT_W + LANE_W];
    end

    always_comb
    begin
        sel_nxt = sel_r;
        if (start)
            sel_nxt = 1'h1;
        else if (desel)
            sel_nxt = 1'h0;
        // first clock out of deselect: lanes stay off even with enable low
        emerge_nxt = start && !sel_r;
        hi_nxt = start ? addr_i[ADDR_W-1:LOW_W] : hi_r;
        wr_pend_nxt = wr_now;
        wr_addr_nxt = eff;
        wr_be_nxt = be;
        rd_pend_nxt = rd_now;
        rd_addr_nxt = eff;
        // one register stage between address and lanes
        dout_nxt = rd_pend_r ? mem[rd_addr_r] : dout_r;
        valid_nxt = valid_r;
        if (desel || wr_now)
            valid_nxt = 1'h0;
        else if (rd_pend_r)
            valid_nxt = 1'h1;
        // sleep drops stale data so the lanes stay floating after wake-up
        // a read already in flight still lands, then is dropped next edge
        else if (sleep_s)
            valid_nxt = 1'h0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_r <= 1'h0;
            emerge_r <= 1'h0;
            hi_r <= '0;
            wr_pend_r <= 1'h0;
            wr_addr_r <= '0;
            wr_be_r <= '0;
            din_r <= '0;
            rd_pend_r <= 1'h0;
            rd_addr_r <= '0;
            dout_r <= '0;
            valid_r <= 1'h0;
        end
        else
        begin
            sel_r <= sel_nxt;
            emerge_r <= emerge_nxt;
            hi_r <= hi_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_be_r <= wr_be_nxt;
            din_r <= din_nxt;
            rd_pend_r <= rd_pend_nxt;
            rd_addr_r <= rd_addr_nxt;
            dout_r <= dout_nxt;
            valid_r <= valid_nxt;
        end
    end

    // self-timed write: commits one edge after the controls were taken
    always_ff @(posedge ref_clk_i)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (wr_pend_r && wr_be_r[i])
                mem[wr_addr_r][i*SLOT_W +: SLOT_W] <=
                    din_r[i*SLOT_W +: SLOT_W];
        end
    end

    // a write in flight floats the lanes whatever output enable says
    assign data_lane_oe_o = !oe_n_s && !sleep_s && valid_r
        && !emerge_r && !wr_pend_r;

    sequence s_cpu_start;
        cpu_ok && sel_now;
    endsequence
    sequence s_ctrl_start;
        !ctrl_addr_strobe_n_i && cpu_addr_strobe_n_i && sel_now
            && !sleep_s;
    endsequence
    property p_cpu_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_cpu_start |=> hi_r == $past(addr_i[ADDR_W-1:LOW_W])
            && cur_low == $past(addr_i[LOW_W-1:0]);
    endproperty
    a_cpu_load: assert property (p_cpu_load)
        else $error("cpu strobe did not load the address");
    property p_ctrl_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_ctrl_start |=> sel_r && hi_r == $past(addr_i[ADDR_W-1:LOW_W])
            && cur_low == $past(addr_i[LOW_W-1:0]);
    endproperty
    a_ctrl_load: assert property (p_ctrl_load)
        else $error("controller strobe did not load the address");
    property p_cpu_ignored;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (chip_sel_primary_n_i && !cpu_addr_strobe_n_i
            && ctrl_addr_strobe_n_i && !sel_r) |=> !sel_r && !rd_pend_r;
    endproperty
    a_cpu_ignored: assert property (p_cpu_ignored)
        else $error("cpu strobe acted with primary select high");
    property p_desel;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!sleep_s && !ctrl_addr_strobe_n_i && !chip_sel_primary_n_i
            && chip_sel_third_n_i) |=> !sel_r && !data_lane_oe_o;
    endproperty
    a_desel: assert property (p_desel)
        else $error("selected without all chip selects");
    property p_both_strobes;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_cpu_start and (!ctrl_addr_strobe_n_i
            && !all_lanes_write_n_i)) |=> !wr_pend_r;
    endproperty
    a_both_strobes: assert property (p_both_strobes)
        else $error("controller strobe acted beside the cpu strobe");
    property p_oe;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        data_lane_oe_o |-> !oe_n_s && valid_r;
    endproperty
    a_oe: assert property (p_oe)
        else $error("lanes driven while output enable high");
    property p_emerge;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (start && !sel_r) |=> !data_lane_oe_o;
    endproperty
    a_emerge: assert property (p_emerge)
        else $error("lanes driven on first clock after deselect");
    property p_sleep;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sleep_s |=> !rd_pend_r && !wr_pend_r && !data_lane_oe_o;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("access taken while asleep");
    property p_din;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_now |=> wr_pend_r
            && din_r[LANE_W-1:0] == $past(data_lane_i[LANE_W-1:0]);
    endproperty
    a_din: assert property (p_din)
        else $error("write data not captured at the edge");
    property p_read_lat;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_now ##1 !(desel || wr_now)) |=> valid_r;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("read data not ready one edge after address");
    property p_global;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_now && !all_lanes_write_n_i) |=> wr_be_r == 4'hf;
    endproperty
    a_global: assert property (p_global)
        else $error("all lanes write missed a lane");
    property p_bwe;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cont && all_lanes_write_n_i && byte_write_enable_n_i)
            |=> !wr_pend_r;
    endproperty
    a_bwe: assert property (p_bwe)
        else $error("lane write without byte write enable");
    property p_lane_sel;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_now && all_lanes_write_n_i) |=>
            wr_be_r == ~$past(lane_write_select_n_i);
    endproperty
    a_lane_sel: assert property (p_lane_sel)
        else $error("lane select did not steer its lane");
endmodule : spb_port

// ---- verif/spb_cpu.sv ----
// spb_cpu: cache controller model driving the memory port bus
// assumes the bench resolves the shared lanes from the port enable alone
`timescale 1ns/100ps
module spb_cpu
    import spb_pkg::*;
(
    input wire logic ref_clk_i,
    output logic [11:0] ctl_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [WORD_W-1:0] word_o,
    output logic drive_o
);
    logic [WORD_W-1:0] last_r;
    initial
    begin
        ctl_o = 12'h5ff;
        addr_o = '0;
        word_o = '0;
        drive_o = 1'b0;
        last_r = '0;
    end
    // ctl: sel1_n sel2 sel3_n cpu_n ctrl_n step_n bwe_n sel_n[3:0] all_n
    // writes are only asked for with bwe_n or all_n low
    task automatic cyc(input logic [11:0] c, input logic [ADDR_W-1:0] a,
        input logic [WORD_W-1:0] w, input logic d);
        @(negedge ref_clk_i);
        ctl_o = c;
        addr_o = a;
        drive_o = d;
        if (d)
            last_r = w;
        // released lanes show no stale value
        word_o = d ? w : ~last_r;
    endtask : cyc
endmodule : spb_cpu

// ---- verif/pipelined_burst_sram_port_tb_top.sv ----
// testbench for the burst memory port with a controller model
// assumes the filtered async pins settle within 6 clock edges
`timescale 1ns/100ps
module pipelined_burst_sram_port_tb_top;
    import spb_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i, oe_n, order, sleep, oe, drv;
    logic [11:0] ctl;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] word, dq;
    logic [DATA_W-1:0] dout;
    logic [LANES-1:0] pout;
    logic tck = 1'b0;
    logic tdi = 1'b0;
    logic tms = 1'b0;
    logic tdo, tdo_oe;
    logic [31:0] seed = 32'h42cbc1f4;
    logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [11:0] neg [4] = '{12'h47e, 12'h97e, 12'h77e, 12'hd7e};
    int mismatches = 0;
    int cmp_count = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    assign dq = oe ? {pout, dout} : word;
    spb_cpu u_spb_cpu (.ref_clk_i(ref_clk_i), .ctl_o(ctl), .addr_o(addr),
        .word_o(word), .drive_o(drv));
    spb_port u_spb_port (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr), .chip_sel_primary_n_i(ctl[11]),
        .chip_sel_second_i(ctl[10]), .chip_sel_third_n_i(ctl[9]),
        .cpu_addr_strobe_n_i(ctl[8]), .ctrl_addr_strobe_n_i(ctl[7]),
        .burst_step_n_i(ctl[6]), .byte_write_enable_n_i(ctl[5]),
        .lane_write_select_n_i(ctl[4:1]), .all_lanes_write_n_i(ctl[0]),
        .out_enable_n_i(oe_n), .burst_order_i(order), .sleep_req_i(sleep),
        .data_lane_i(dq[DATA_W-1:0]), .parity_lane_i(dq[WORD_W-1:DATA_W]),
        .data_lane_o(dout), .parity_lane_o(pout), .data_lane_oe_o(oe),
        .scan_clk_i(tck), .scan_in_i(tdi), .scan_mode_i(tms),
        .scan_out_o(tdo), .scan_out_oe_o(tdo_oe));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [WORD_W-1:0] rw();
        logic [63:0] t;
        t = {rnd(), rnd()};
        return t[WORD_W-1:0];
    endfunction : rw
    function automatic logic [1:0] lo(input logic [1:0] s, c);
        return order == ORDER_LINEAR ? s + c : s ^ c;
    endfunction : lo
    // lanes written by a controller strobe cycle; refused ones give none
    function automatic logic [3:0] lanes(input logic [11:0] c);
        if (c[11:7] != 5'b01010 || sleep)
            return 4'h0;
        return !c[0] ? 4'hf : c[5] ? 4'h0 : ~c[4:1];
    endfunction : lanes
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o,
        n, input logic [3:0] m);
        for (int i = 0; i < LANES; i++)
        begin
            if (m[i])
            begin
                o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
                o[DATA_W + i] = n[DATA_W + i];
            end
        end
        return o;
    endfunction : merge
    task automatic chk(input logic [WORD_W-1:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] c, input logic [ADDR_W-1:0] a);
        logic [WORD_W-1:0] w;
        w = rw();
        u_spb_cpu.cyc(c, a, w, 1'b1);
        mem[a] = merge(mem[a], w, lanes(c));
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input int n,
        input logic cpu, input logic ds);
        logic [ADDR_W-1:0] ra;
        if (ds)
        begin
            u_spb_cpu.cyc(12'hd7f, a, '0, 1'b0);
            u_spb_cpu.cyc(12'hcff, a, '0, 1'b0);
        end
        u_spb_cpu.cyc(cpu ? 12'h4ff : 12'h57f, a, '0, 1'b0);
        for (int i = 0; i <= n; i++)
        begin
            u_spb_cpu.cyc(i < n - 1 ? 12'h5bf : 12'h5ff, a, '0, 1'b0);
            if (i == 0 && ds)
                chk(WORD_W'(oe), '0);
            if (i > 0)
            begin
                ra = {a[ADDR_W-1:2], lo(a[1:0], 2'(i - 1))};
                chk({pout, dout}, mem[ra]);
            end
        end
        chk(WORD_W'(oe), WORD_W'(!oe_n));
    endtask : rd
    // scan pins are filtered, so each level is held for six clocks
    task automatic tck_cyc(input logic m, input logic d);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (6) @(negedge ref_clk_i);
        tck = 1'b1;
        repeat (6) @(negedge ref_clk_i);
    endtask : tck_cyc
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial
    begin
        logic [31:0] r;
        logic [31:0] t;
        logic [ADDR_W-1:0] a;
        rst_n_i = 1'b0;
        oe_n = 1'b0;
        order = 1'b1;
        sleep = 1'b0;
        a = '0;
        repeat (6) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        for (int k = 0; k < 4; k++)
            tck_cyc(k == 1, 1'b0);
        t = '0;
        for (int k = 0; k < 8; k++)
        begin
            r = rnd();
            tck_cyc(1'b0, r[0]);
            chk(WORD_W'(tdo), WORD_W'(t[0]));
            chk(WORD_W'(tdo_oe), WORD_W'(1'b1));
            t = r;
        end
        for (int k = 0; k < 40; k++)
        begin
            r = rnd();
            t = rnd();
            a = t[ADDR_W-1:0];
            // strap moves only while the bus is idle
            order = r[0];
            // outputs held off while the controller drives the lanes
            oe_n = 1'b1;
            repeat (6) @(negedge ref_clk_i);
            for (int j = 0; j < 4; j++)
                wr(12'h57e, {a[ADDR_W-1:2], 2'(j)});
            wr({5'b01010, 1'b1, r[2], r[6:3], r[7]}, a);
            wr(neg[r[9:8]], a);
            u_spb_cpu.cyc(12'h5ff, a, '0, 1'b0);
            oe_n = r[1];
            repeat (6) @(negedge ref_clk_i);
            rd(a, 4, r[10], r[11]);
        end
        sleep = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        wr(12'h57e, a);
        u_spb_cpu.cyc(12'h5ff, a, '0, 1'b0);
        sleep = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        rd(a, 1, 1'b0, 1'b0);
        finish_test();
    end
endmodule : pipelined_burst_sram_port_tb_top
